// *** dv/source_core_model.sv ***
/*
  Behavioural stand-in for the interrupt sources and the core that
  takes vectors. Assumes its tasks are called from the falling-edge side.
*/
`timescale 1ns/1ps
module source_core_model (
  input wire logic core_clk,                         // System clock
  output logic [intvec_pkg::NUM_SRC-1:0] src_event,  // Source event pulses
  output logic core_ack                              // Core takes the vector
);
  import intvec_pkg::*;
  // Quiet at time zero
  initial begin
    src_event = '0;
    core_ack = 1'b0;
  end
  // Raise the chosen sources for exactly one cycle
  task automatic fire(input logic [NUM_SRC-1:0] mask);
    @(negedge core_clk);
    src_event = mask;
    @(negedge core_clk);
    src_event = '0;
  endtask : fire
  // Core takes the presented vector for one cycle
  task automatic ack();
    @(negedge core_clk);
    core_ack = 1'b1;
    @(negedge core_clk);
    core_ack = 1'b0;
  endtask : ack
endmodule : source_core_model

// *** dv/tb.sv ***
/*
  Self-checking bench for the interrupt vector map.
  Assumes the source/core model drives events and acks on falling edges.
*/
`timescale 1ns/1ps
module tb;
  import intvec_pkg::*;
  localparam logic [63:0] RSVD = 64'hFDF9_FF80_00E0_8000;  // Unimplemented flag bits
  // Source index and expected vector
  localparam int MAP [26][2] = '{
    '{0, 8}, '{1, 9}, '{2, 10}, '{4, 12},
    '{9, 17}, '{10, 18}, '{11, 19}, '{12, 20},
    '{13, 21}, '{15, 24}, '{16, 25},
    '{17, 26}, '{18, 27}, '{19, 28},
    '{20, 32}, '{25, 37}, '{26, 38}, '{27, 39},
    '{30, 42}, '{31, 43}, '{32, 44},
    '{33, 45}, '{34, 46}, '{35, 57},
    '{36, 58}, '{37, 65}};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [63:0] enables = '1;
  logic [PRIO_BITS-1:0] priority_words = {60{4'h1}};
  logic [FLAG_BITS-1:0] flag_clear = '0;
  wire [NUM_SRC-1:0] src_event;
  wire core_ack;
  wire [63:0] flags;
  wire req_valid;
  wire [VEC_W-1:0] req_vector;
  wire [IRQ_W-1:0] req_irq;
  wire [ADDR_W-1:0] req_address;
  wire [PRIO_W-1:0] req_level;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;

  interrupt_vector_map i_interrupt_vector_map (
    .core_clk(core_clk), .reset(reset), .src_event(src_event),
    .request_enable_word_0(enables[15:0]), .request_enable_word_1(enables[31:16]),
    .request_enable_word_2(enables[47:32]), .request_enable_word_3(enables[63:48]),
    .priority_words(priority_words), .flag_clear(flag_clear), .core_ack(core_ack),
    .pending_flag_word_0(flags[15:0]), .pending_flag_word_1(flags[31:16]),
    .pending_flag_word_2(flags[47:32]), .pending_flag_word_3(flags[63:48]),
    .req_valid(req_valid), .req_vector(req_vector), .req_irq(req_irq),
    .req_address(req_address), .req_level(req_level));

  source_core_model i_source_core_model (
    .core_clk(core_clk), .src_event(src_event), .core_ack(core_ack));

  // Clock, 100 ns period
  always #50 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      end_sim();
    end
  end

  // Compare one observed value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at time %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    chk(flags, 64'h0);
    chk(req_valid, 1'b0);
    reset = 1'b0;
    // Each of the 26 sources in MAP alone
    for (int k = 0; k < 26; k++) begin
      i_source_core_model.fire(38'h1 << MAP[k][0]);
      @(negedge core_clk);
      chk(flags, 64'h1 << (MAP[k][1] - 8));
      chk(req_vector, MAP[k][1]);
      chk(req_irq, MAP[k][1] - 8);
      chk(req_address, 'h14 + 2 * (MAP[k][1] - 8));
      i_source_core_model.ack();
      chk(req_valid, 1'b0);
      chk(flags, 64'h0);
    end
    // Equal levels, then a raised level
    i_source_core_model.fire(38'h10_0000_0002);
    @(negedge core_clk);
    chk(req_vector, 7'h09);
    i_source_core_model.ack();
    chk(req_vector, 7'h3A);
    priority_words[202:200] = 3'h5;
    i_source_core_model.fire(38'h2);
    @(negedge core_clk);
    chk(req_vector, 7'h3A);
    chk(req_level, 3'h5);
    i_source_core_model.ack();
    chk(req_vector, 7'h09);
    i_source_core_model.ack();
    priority_words[202:200] = 3'h1;
    // Enable and level gating
    enables[0] = 1'b0;
    i_source_core_model.fire(38'h1);
    @(negedge core_clk);
    chk(flags, 64'h1);
    chk(req_valid, 1'b0);
    enables[0] = 1'b1;
    @(negedge core_clk);
    chk(req_vector, 7'h08);
    priority_words[2:0] = 3'h0;
    @(negedge core_clk);
    chk(req_valid, 1'b0);
    priority_words[2:0] = 3'h1;
    flag_clear[0] = 1'b1;
    @(negedge core_clk);
    flag_clear[0] = 1'b0;
    chk(flags, 64'h0);
    // Event and clear on one edge: the set wins
    @(negedge core_clk);
    flag_clear[0] = 1'b1;
    i_source_core_model.fire(38'h1);
    flag_clear[0] = 1'b0;
    chk(flags, 64'h1);
    // All sources at once: reserved slots stay empty
    i_source_core_model.fire('1);
    @(negedge core_clk);
    chk(flags, ~RSVD);
    chk(req_vector, 7'h08);
    flag_clear = '1;
    @(negedge core_clk);
    flag_clear = '0;
    chk(flags, 64'h0);
    end_sim();
  end
endmodule : tb

// *** src/interrupt_vector_map.sv ***
/*
  Interrupt vector map: pending flags per source, enable and priority
  gating, and an arbiter presenting the winning vector to the core.
  Assumes source events, enables, priorities and clears come from logic
  on core_clk, so none of them is synchronised.
*/
// Overview of operation
// RULE1 - External request zero: vector 8, 0x000014
// RULE2 - Capture one: vector 9, 0x000016
// RULE3 - Compare one: vector 10, 0x000018
// RULE4 - DMA channel zero: vector 12, 0x00001C
// RULE5 - Serial port one error 17, done 18
// RULE6 - Async port one receive: vector 19
// RULE7 - Async port one transmit: vector 20
// RULE8 - Converter done: vector 21, 0x00002E
// RULE9 - Two-wire one slave: vector 24
// RULE10 - Two-wire one master: vector 25
// RULE11 - Comparator events combined: vector 26
// RULE12 - Pin change: vector 27, 0x00003A
// RULE13 - External one vector 28; 29-31 reserved
// RULE14 - DMA channel two: vector 32, 0x000044
// RULE15 - External request two: vector 37
// RULE16 - Async port two: vectors 38, 39
// RULE17 - Bus node variant: vectors 42, 43
// RULE18 - DMA channel three: vector 44, 0x00005C
// RULE19 - Capture three, four: vectors 45, 46
// RULE20 - Two-wire two slave 57; 47-56 reserved
// RULE21 - Two-wire two master 58; 59-64 reserved
// RULE22 - PWM variant: special match vector 65
// RULE23 - Equal priority: lowest vector wins
// RULE24 - Request needs flag, enable, nonzero priority
`timescale 1ns/1ps
module interrupt_vector_map #(
  parameter bit HAS_BUS_NODE = 1'b1,  // Variant has the bus node module
  parameter bit HAS_PWM = 1'b1        // Variant has motor-control PWM
) (
  input wire logic core_clk,                                         // System clock, 10 MHz
  input wire logic reset,                                            // Sync reset, active high
  input wire logic [intvec_pkg::NUM_SRC-1:0] src_event,              // Source event pulses
  input wire logic [intvec_pkg::WORD_W-1:0] request_enable_word_0,   // Enables IRQ 0-15
  input wire logic [intvec_pkg::WORD_W-1:0] request_enable_word_1,   // Enables IRQ 16-31
  input wire logic [intvec_pkg::WORD_W-1:0] request_enable_word_2,   // Enables IRQ 32-47
  input wire logic [intvec_pkg::WORD_W-1:0] request_enable_word_3,   // Enables IRQ 48-63
  input wire logic [intvec_pkg::PRIO_BITS-1:0] priority_words,       // Priority words 0-14
  input wire logic [intvec_pkg::FLAG_BITS-1:0] flag_clear,           // Software clear per IRQ
  input wire logic core_ack,                                         // Core takes the vector
  output logic [intvec_pkg::WORD_W-1:0] pending_flag_word_0,         // Flags IRQ 0-15
  output logic [intvec_pkg::WORD_W-1:0] pending_flag_word_1,         // Flags IRQ 16-31
  output logic [intvec_pkg::WORD_W-1:0] pending_flag_word_2,         // Flags IRQ 32-47
  output logic [intvec_pkg::WORD_W-1:0] pending_flag_word_3,         // Flags IRQ 48-63
  output logic req_valid,                                            // A request is presented
  output logic [intvec_pkg::VEC_W-1:0] req_vector,                   // Winning vector number
  output logic [intvec_pkg::IRQ_W-1:0] req_irq,                      // Winning IRQ number
  output logic [intvec_pkg::ADDR_W-1:0] req_address,                 // Winning table address
  output logic [intvec_pkg::PRIO_W-1:0] req_level                    // Winning priority
);
  import intvec_pkg::*;

  logic [FLAG_BITS-1:0] flag_reg;
  logic [FLAG_BITS-1:0] enable_all;
  logic [NUM_SRC-1:0] src_avail;
  logic [NUM_SRC-1:0] src_taken;
  logic win_found;
  logic [SRC_W-1:0] win_idx;
  logic [PRIO_W-1:0] win_lvl;
  logic req_valid_reg;
  logic [SRC_W-1:0] req_idx_reg;
  logic [VEC_W-1:0] req_vector_reg;
  logic [IRQ_W-1:0] req_irq_reg;
  logic [ADDR_W-1:0] req_address_reg;
  logic [PRIO_W-1:0] req_level_reg;

  // Parameters are single bits, so only the flag and priority geometry can be wrong
  if (FLAG_BITS < PRIO_BITS / PRIO_STRIDE) begin : g_geometry_bad
    $error("flag and priority geometry disagree");
  end

  assign enable_all = {request_enable_word_3, request_enable_word_2,
                       request_enable_word_1, request_enable_word_0};
  assign pending_flag_word_0 = flag_reg[WORD_W-1:0];
  assign pending_flag_word_1 = flag_reg[2*WORD_W-1:WORD_W];
  assign pending_flag_word_2 = flag_reg[3*WORD_W-1:2*WORD_W];
  assign pending_flag_word_3 = flag_reg[4*WORD_W-1:3*WORD_W];

  // Availability per source and the source cleared by the core this cycle
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      if (g == SRC_BUS_NODE_RX || g == SRC_BUS_NODE_EVT) begin : g_bus
        // RULE17 variant-only sources
        assign src_avail[g] = HAS_BUS_NODE;
      end else if (g == SRC_PWM_MATCH) begin : g_pwm
        // RULE22 variant-only source
        assign src_avail[g] = HAS_PWM;
      end else begin : g_std
        assign src_avail[g] = 1'b1;
      end
      assign src_taken[g] = core_ack && req_valid_reg && (req_idx_reg == SRC_W'(g));
    end
  endgenerate

  // Flags: event sets, software or core acknowledge clears, set wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        // RULE13 only mapped IRQs own flags, reserved stay zero
        flag_reg[irq_of(SRC_VECTOR[i])] <= (src_event[i] && src_avail[i]) ||
          (flag_reg[irq_of(SRC_VECTOR[i])] && !flag_clear[irq_of(SRC_VECTOR[i])] &&
           !src_taken[i]);
      end
    end
  end

  // Arbiter: highest level wins, ascending scan keeps lowest vector on ties
  always_comb begin
    logic [IRQ_W-1:0] irq;
    logic [PRIO_W-1:0] lvl;
    irq = '0;
    lvl = '0;
    win_found = 1'b0;
    win_idx = '0;
    win_lvl = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      irq = irq_of(SRC_VECTOR[i]);
      lvl = priority_words[PRIO_STRIDE*irq +: PRIO_W];
      // RULE24 flag, enable and nonzero priority all needed
      // RULE23 strict compare keeps the earlier vector
      if (flag_reg[irq] && enable_all[irq] && lvl != '0 && !src_taken[i] &&
          lvl > win_lvl) begin
        win_found = 1'b1;
        win_idx = i[SRC_W-1:0];
        win_lvl = lvl;
      end
    end
  end

  // Presented request, registered; vector, IRQ and address from the table
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_valid_reg <= 1'b0;
      req_idx_reg <= '0;
      req_vector_reg <= '0;
      req_irq_reg <= '0;
      req_address_reg <= '0;
      req_level_reg <= '0;
    end else begin
      req_valid_reg <= win_found;
      req_idx_reg <= win_idx;
      req_level_reg <= win_lvl;
      // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE7 table lookup
      // RULE8 RULE9 RULE10 RULE11 RULE12 RULE14 RULE15 table lookup
      // RULE16 RULE18 RULE19 RULE20 RULE21 table lookup
      req_vector_reg <= win_found ? SRC_VECTOR[win_idx] : '0;
      req_irq_reg <= win_found ? irq_of(SRC_VECTOR[win_idx]) : '0;
      req_address_reg <= win_found ? addr_of(SRC_VECTOR[win_idx]) : '0;
    end
  end

  assign req_valid = req_valid_reg;
  assign req_vector = req_vector_reg;
  assign req_irq = req_irq_reg;
  assign req_address = req_address_reg;
  assign req_level = req_level_reg;

  // Mapping check: a presented vector carries its IRQ and table address
  property vec_map_p(logic [6:0] v, logic [5:0] q, logic [23:0] a);
    @(posedge core_clk) disable iff (reset)
      (req_valid && req_vector == v) |-> (req_irq == q && req_address == a);
  endproperty

  ext_zero_map_a: assert property (vec_map_p(7'd8, 6'd0, 24'h000014)) // RULE1
    else $error("external zero mapping wrong");
  capture_one_map_a: assert property (vec_map_p(7'd9, 6'd1, 24'h000016)) // RULE2
    else $error("capture one mapping wrong");
  compare_one_map_a: assert property (vec_map_p(7'd10, 6'd2, 24'h000018)) // RULE3
    else $error("compare one mapping wrong");
  dma_zero_map_a: assert property (vec_map_p(7'd12, 6'd4, 24'h00001C)) // RULE4
    else $error("dma zero mapping wrong");
  serial_done_map_a: assert property (vec_map_p(7'd18, 6'd10, 24'h000028)) // RULE5
    else $error("serial done mapping wrong");
  async_rx_map_a: assert property (vec_map_p(7'd19, 6'd11, 24'h00002A)) // RULE6
    else $error("async one receive mapping wrong");
  async_tx_map_a: assert property (vec_map_p(7'd20, 6'd12, 24'h00002C)) // RULE7
    else $error("async one transmit mapping wrong");
  converter_map_a: assert property (vec_map_p(7'd21, 6'd13, 24'h00002E)) // RULE8
    else $error("converter mapping wrong");
  two_wire_slave_a: assert property (vec_map_p(7'd24, 6'd16, 24'h000034)) // RULE9
    else $error("two-wire one slave mapping wrong");
  two_wire_master_a: assert property (vec_map_p(7'd25, 6'd17, 24'h000036)) // RULE10
    else $error("two-wire one master mapping wrong");
  comparator_map_a: assert property (vec_map_p(7'd26, 6'd18, 24'h000038)) // RULE11
    else $error("comparator mapping wrong");
  pin_change_map_a: assert property (vec_map_p(7'd27, 6'd19, 24'h00003A)) // RULE12
    else $error("pin change mapping wrong");
  dma_two_map_a: assert property (vec_map_p(7'd32, 6'd24, 24'h000044)) // RULE14
    else $error("dma two mapping wrong");
  ext_two_map_a: assert property (vec_map_p(7'd37, 6'd29, 24'h00004E)) // RULE15
    else $error("external two mapping wrong");
  async_two_map_a: assert property (vec_map_p(7'd39, 6'd31, 24'h000052)) // RULE16
    else $error("async two transmit mapping wrong");
  bus_node_map_a: assert property (vec_map_p(7'd43, 6'd35, 24'h00005A)) // RULE17
    else $error("bus node event mapping wrong");
  dma_three_map_a: assert property (vec_map_p(7'd44, 6'd36, 24'h00005C)) // RULE18
    else $error("dma three mapping wrong");
  capture_four_map_a: assert property (vec_map_p(7'd46, 6'd38, 24'h000060)) // RULE19
    else $error("capture four mapping wrong");
  two_wire_two_a: assert property (vec_map_p(7'd57, 6'd49, 24'h000076)) // RULE20
    else $error("two-wire two slave mapping wrong");
  master_two_map_a: assert property (vec_map_p(7'd58, 6'd50, 24'h000078)) // RULE21
    else $error("two-wire two master mapping wrong");
  pwm_match_map_a: assert property (vec_map_p(7'd65, 6'd57, 24'h000086)) // RULE22
    else $error("pwm match mapping wrong");

  // Reserved IRQs never hold a flag
  reserved_low_zero_a: assert property (@(posedge core_clk) disable iff (reset) // RULE13
    flag_reg[23:21] == 3'h0) else $error("reserved flag 21-23 set");
  reserved_mid_zero_a: assert property (@(posedge core_clk) disable iff (reset) // RULE20
    flag_reg[48:39] == 10'h000) else $error("reserved flag 39-48 set");
  reserved_high_zero_a: assert property (@(posedge core_clk) disable iff (reset) // RULE21
    flag_reg[56:51] == 6'h00) else $error("reserved flag 51-56 set");

  // Gating: nothing pending and enabled means nothing presented next cycle
  request_gating_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    (((flag_reg & enable_all) == '0) |=> !req_valid) and (req_valid |-> req_level != 3'h0))
    else $error("request presented without flag, enable or level");

  // Top level on the first source always wins at once
  sequence top_ext_zero_s;
    flag_reg[0] && enable_all[0] && priority_words[2:0] == 3'h7 && !src_taken[SRC_EXT_ZERO];
  endsequence
  natural_order_a: assert property (@(posedge core_clk) disable iff (reset) // RULE23
    top_ext_zero_s |=> (req_valid && req_vector == 7'd8))
    else $error("lowest vector lost a tie at top level");

  // Acknowledge clears the taken flag unless a new event arrives
  sequence ack_s;
    req_valid && core_ack && !src_event[req_idx_reg];
  endsequence
  ack_clears_flag_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    ack_s |=> !flag_reg[$past(req_irq)]) else $error("acknowledged flag still set");

  // Set beats a simultaneous clear
  set_wins_clear_a: assert property (@(posedge core_clk) disable iff (reset) // RULE1
    (src_event[SRC_EXT_ZERO] && flag_clear[0]) |=> flag_reg[0])
    else $error("event lost against clear");

  // Mapping of the remaining table sources, not in vector order
  serial_error_map_a: assert property (vec_map_p(7'd17, 6'd9, 24'h000026)) // RULE5
    else $error("serial one error mapping wrong");
  ext_one_map_a: assert property (vec_map_p(7'd28, 6'd20, 24'h00003C)) // RULE13
    else $error("external one mapping wrong");
  async_two_rx_a: assert property (vec_map_p(7'd38, 6'd30, 24'h000050)) // RULE16
    else $error("async two receive mapping wrong");
  bus_node_rx_a: assert property (vec_map_p(7'd42, 6'd34, 24'h000058)) // RULE17
    else $error("bus node receive mapping wrong");
  capture_three_a: assert property (vec_map_p(7'd45, 6'd37, 24'h00005E)) // RULE19
    else $error("capture three mapping wrong");
  timer_one_map_a: assert property (vec_map_p(7'd11, 6'd3, 24'h00001A)) // RULE23
    else $error("timer one mapping wrong");
  capture_two_map_a: assert property (vec_map_p(7'd13, 6'd5, 24'h00001E)) // RULE23
    else $error("capture two mapping wrong");
  compare_two_map_a: assert property (vec_map_p(7'd14, 6'd6, 24'h000020)) // RULE23
    else $error("compare two mapping wrong");
  timer_two_map_a: assert property (vec_map_p(7'd15, 6'd7, 24'h000022)) // RULE23
    else $error("timer two mapping wrong");
  timer_three_map_a: assert property (vec_map_p(7'd16, 6'd8, 24'h000024)) // RULE23
    else $error("timer three mapping wrong");
  dma_one_map_a: assert property (vec_map_p(7'd22, 6'd14, 24'h000030)) // RULE23
    else $error("dma one mapping wrong");
  compare_three_a: assert property (vec_map_p(7'd33, 6'd25, 24'h000046)) // RULE23
    else $error("compare three mapping wrong");
  compare_four_a: assert property (vec_map_p(7'd34, 6'd26, 24'h000048)) // RULE23
    else $error("compare four mapping wrong");
  timer_four_map_a: assert property (vec_map_p(7'd35, 6'd27, 24'h00004A)) // RULE23
    else $error("timer four mapping wrong");
  timer_five_map_a: assert property (vec_map_p(7'd36, 6'd28, 24'h00004C)) // RULE23
    else $error("timer five mapping wrong");
  serial_two_err_a: assert property (vec_map_p(7'd40, 6'd32, 24'h000054)) // RULE23
    else $error("serial two error mapping wrong");
  serial_two_done_a: assert property (vec_map_p(7'd41, 6'd33, 24'h000056)) // RULE23
    else $error("serial two done mapping wrong");

  // Absent variant modules never raise their flags
  bus_node_absent_a: assert property (@(posedge core_clk) disable iff (reset) // RULE17
    !HAS_BUS_NODE |-> flag_reg[35:34] == 2'h0) else $error("absent bus node flag set");
  pwm_absent_a: assert property (@(posedge core_clk) disable iff (reset) // RULE22
    !HAS_PWM |-> !flag_reg[57]) else $error("absent pwm flag set");

  // Every available source event shows as a flag one cycle later
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_set_chk
      flag_set_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
        (src_event[g] && src_avail[g]) |=> flag_reg[irq_of(SRC_VECTOR[g])])
        else $error("source event did not set its flag");
    end
  endgenerate

  // Sync reset empties every flag and the presented request
  reset_clears_a: assert property (@(posedge core_clk) // RULE24
    reset |=> (flag_reg == '0 && !req_valid && req_vector == 7'h00))
    else $error("reset left state behind");

  // With nothing presented every request field reads zero
  idle_outputs_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    !req_valid |-> (req_vector == 7'h00 && req_irq == 6'h00 &&
      req_address == 24'h000000 && req_level == 3'h0))
    else $error("idle request fields not zero");

  // Presented vectors stay inside the implemented table
  vector_range_a: assert property (@(posedge core_clk) disable iff (reset) // RULE13
    req_valid |-> (req_vector >= 7'd8 && req_vector <= 7'd65))
    else $error("vector outside the table");

  // Level zero or enable low keeps the first source off the core
  level_zero_block_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    (priority_words[2:0] == 3'h0) |=> !(req_valid && req_vector == 7'd8))
    else $error("level zero source presented");
  enable_low_block_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    !enable_all[0] |=> !(req_valid && req_vector == 7'd8))
    else $error("disabled source presented");

  // Software clear without a new event empties the flag
  clear_empties_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    (flag_clear[0] && !src_event[SRC_EXT_ZERO]) |=> !flag_reg[0])
    else $error("cleared flag still set");

  // A flag with no clear and no acknowledge is held
  flag_holds_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    (flag_reg[0] && !flag_clear[0] && !src_taken[SRC_EXT_ZERO]) |=> flag_reg[0])
    else $error("pending flag lost");

  // An acknowledged source is not presented again at once
  ack_moves_on_a: assert property (@(posedge core_clk) disable iff (reset) // RULE24
    ack_s |=> !(req_valid && req_irq == $past(req_irq)))
    else $error("acknowledged source presented again");

  // The first source at equal or higher level beats capture one
  sequence first_ahead_s;
    flag_reg[0] && enable_all[0] && priority_words[2:0] != 3'h0 &&
      priority_words[2:0] >= priority_words[6:4] && !src_taken[SRC_EXT_ZERO];
  endsequence
  tie_order_a: assert property (@(posedge core_clk) disable iff (reset) // RULE23
    first_ahead_s |=> !(req_valid && req_vector == 7'd9))
    else $error("later vector won a tie");
endmodule : interrupt_vector_map

// *** src/intvec_pkg.sv ***
/*
  Constants for the interrupt vector map: widths, table geometry and the
  vector number of every implemented source, listed in natural order.
  Assumes flag and enable bit n and priority field n belong to IRQ n.
*/
package intvec_pkg;
  localparam int NUM_SRC = 38;     // Implemented sources
  localparam int WORD_W = 16;      // Width of every flag, enable and priority word
  localparam int FLAG_WORDS = 4;   // Flag and enable words
  localparam int PRIO_WORDS = 15;  // Priority words
  localparam int FLAG_BITS = FLAG_WORDS * WORD_W;
  localparam int PRIO_BITS = PRIO_WORDS * WORD_W;
  localparam int PRIO_W = 3;       // Priority field width
  localparam int PRIO_STRIDE = 4;  // Priority field spacing per IRQ, in bits
  localparam int VEC_W = 7;
  localparam int IRQ_W = 6;
  localparam int ADDR_W = 24;
  localparam int SRC_W = 6;
  localparam logic [VEC_W-1:0] VEC_BASE = 7'h08;           // Vector of IRQ 0
  localparam logic [ADDR_W-1:0] TABLE_BASE = 24'h000004;   // Table address of vector 0
  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000002;    // Bytes per table entry

  // Source indices of the variant-dependent and checked sources
  localparam int SRC_EXT_ZERO = 0;
  localparam int SRC_BUS_NODE_RX = 30;
  localparam int SRC_BUS_NODE_EVT = 31;
  localparam int SRC_PWM_MATCH = 37;

  typedef logic [VEC_W-1:0] vec_t;

  // Vector numbers in natural order; lower index wins ties
  localparam vec_t SRC_VECTOR [NUM_SRC] = '{
    7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h0E, 7'h0F,  // ext0 .. timer2
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16,         // timer3 .. dma1
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C,                       // two-wire 1 .. ext1
    7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,  // dma_channel_two_req .. async 2 tx
    7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E,         // serial 2 .. capture 4
    7'h39, 7'h3A, 7'h41                                      // two-wire 2, pwm match
  };

  // IRQ number of a vector
  function automatic logic [IRQ_W-1:0] irq_of(input vec_t vec);
    vec_t diff;
    diff = vec - VEC_BASE;
    return diff[IRQ_W-1:0];
  endfunction : irq_of

  // Vector-table address of a vector
  function automatic logic [ADDR_W-1:0] addr_of(input vec_t vec);
    return TABLE_BASE + ADDR_STEP * {{(ADDR_W-VEC_W){1'b0}}, vec};
  endfunction : addr_of
endpackage : intvec_pkg
